// >>> logic/pbc_pll_ctrl.sv
/*
 * APB-visible control of PLL bandwidth, lock detection and base clock selection.
 * Assumes an APB master on pclk and asynchronous crystal and VCO clock pins.
 */
`timescale 1ns/1ps
`default_nettype none


module pbc_pll_ctrl
	import pbc_pkg::*;
(
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// source clocks
	input  wire logic        xtal_clk,
	input  wire logic        vco_clk,
	// outputs to the analog loop and the system
	output logic             base_clk_out,
	output logic             loop_active,
	output logic             filter_track,
	output logic      [3:0]  fb_mult,
	output logic      [3:0]  range_mult,
	output logic             lock_irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic        lock_irq_en;
	logic        lock_change_flag;
	logic        loop_enable;
	logic        base_src_sel;
	logic        auto_mode;
	logic        lock_st;
	logic        auto_track;
	logic        manual_track;
	logic [7:0]  loop_prog_reg;
	logic [3:0]  win_cnt;
	logic [7:0]  vco_cnt;
	logic        using_vco;
	logic        xtal_rise;
	logic        vco_rise;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire        acc_first = psel & penable & ~pready;
	wire        acc_done  = psel & penable & pready;
	wire        hit_ctrl  = (paddr == ADDR_CTRL);
	wire        hit_bw    = (paddr == ADDR_BW);
	wire        hit_prog  = (paddr == ADDR_PROG);
	wire        hit_any   = hit_ctrl | hit_bw | hit_prog;
	wire        wr_ctrl   = acc_done & pwrite & hit_ctrl;
	wire        wr_bw     = acc_done & pwrite & hit_bw;
	wire        wr_prog   = acc_done & pwrite & hit_prog;
	wire        rd_ctrl   = acc_done & ~pwrite & hit_ctrl;

	wire [3:0]  prog_n    = loop_prog_reg[7:4];
	wire [3:0]  prog_l    = loop_prog_reg[3:0];
	wire        l_zero    = (prog_l == 4'h0);
	wire        next_l_zero = wr_prog ? (pwdata[3:0] == 4'h0) : l_zero;

	wire [7:0]  ctrl_word = {auto_mode & lock_irq_en, auto_mode & lock_change_flag,
	                         loop_enable, base_src_sel, CTRL_UNUSED};
	wire [7:0]  bw_word   = {auto_mode, auto_mode & lock_st,
	                         auto_mode ? auto_track : manual_track, 5'h00};
	wire [7:0]  rd_byte   = hit_ctrl ? ctrl_word :
	                        hit_bw   ? bw_word   :
	                        hit_prog ? loop_prog_reg : 8'h00;

	// ----------------------------------------------------------------
	// control write interlocks
	// ----------------------------------------------------------------
	wire        wr_en_bit   = pwdata[CTRL_ENABLE];
	wire        wr_bsel_bit = pwdata[CTRL_BSEL];
	wire        en_change   = wr_ctrl & (wr_en_bit != loop_enable);
	wire        bsel_change = wr_ctrl & (wr_bsel_bit != base_src_sel);
	wire        both_change = en_change & bsel_change;
	// clearing enable is refused while base_src_sel selects the vco as base clock
	wire        next_enable = (en_change && !both_change && !(base_src_sel && !wr_en_bit))
	                          ? wr_en_bit : loop_enable;
	// setting select needs the loop already on and a usable range
	wire        bsel_req    = (bsel_change && !both_change) ? wr_bsel_bit : base_src_sel;
	wire        next_bsel   = bsel_req & loop_enable & ~next_l_zero;

	// ----------------------------------------------------------------
	// lock detector: count vco edges over a crystal window
	// ----------------------------------------------------------------
	wire        det_run     = auto_mode & loop_active;
	wire        win_end     = xtal_rise & (win_cnt == 4'(REF_WIN - 4'h1));
	wire [7:0]  vco_now     = (vco_rise && vco_cnt != 8'hff) ? 8'(vco_cnt + 8'h01) : vco_cnt;
	wire [7:0]  expect_cnt  = {4'h0, pbc_n_eff(prog_n)} * {4'h0, REF_WIN};
	wire [7:0]  err_cnt     = pbc_absdiff(vco_now, expect_cnt);
	wire        next_lock   = lock_st ? (err_cnt <= UNLOCK_TOL) : (err_cnt <= LOCK_TOL);
	wire        next_track  = auto_track ? (err_cnt <= UNTRACK_TOL)
	                                     : (err_cnt <= TRACK_TOL);
	// turning the loop off in auto mode also drops lock, which counts as a toggle
	wire        lock_drop   = auto_mode & ~loop_active & lock_st;
	wire        lock_set    = (det_run & win_end & (next_lock != lock_st)) | lock_drop;
	wire        next_filter = auto_mode ? auto_track : manual_track;

	// ----------------------------------------------------------------
	// apb answer: one wait state, data and error with pready
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'h0;
			pslverr <= 1'h0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready  <= acc_first;
			pslverr <= acc_first & ~hit_any;
			if (acc_first) begin
				prdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	// ----------------------------------------------------------------
	// software-written registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_irq_en   <= 1'h0;
			loop_enable   <= ENABLE_RST;
			base_src_sel  <= 1'h0;
			auto_mode     <= 1'h0;
			manual_track  <= 1'h0;
			loop_prog_reg <= PROG_RST;
		end else if (ce) begin
			loop_enable  <= next_enable;
			base_src_sel <= next_bsel;
			if (wr_ctrl && auto_mode) begin
				lock_irq_en <= pwdata[CTRL_IRQ_EN];
			end
			if (wr_bw) begin
				auto_mode <= pwdata[BW_AUTO];
			end
			// auto mode keeps the last manual value aside for when manual resumes
			if (wr_bw && !auto_mode) begin
				manual_track <= pwdata[BW_TRACK];
			end
			if (wr_prog) begin
				loop_prog_reg <= pwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// lock, tracking and change flag
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_st          <= 1'h0;
			auto_track       <= 1'h0;
			lock_change_flag <= 1'h0;
			win_cnt          <= 4'h0;
			vco_cnt          <= 8'h00;
		end else if (ce) begin
			if (!det_run) begin
				lock_st    <= 1'h0;
				auto_track <= 1'h0;
				win_cnt    <= 4'h0;
				vco_cnt    <= 8'h00;
			end else if (win_end) begin
				lock_st    <= next_lock;
				auto_track <= next_track;
				win_cnt    <= 4'h0;
				vco_cnt    <= 8'h00;
			end else begin
				win_cnt    <= xtal_rise ? 4'(win_cnt + 4'h1) : win_cnt;
				vco_cnt    <= vco_now;
			end
			// a toggle landing on the clearing read still sets the flag
			if (lock_set) begin
				lock_change_flag <= 1'h1;
			end else if (rd_ctrl) begin
				lock_change_flag <= 1'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs to the loop and interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_active  <= 1'h0;
			filter_track <= 1'h0;
			fb_mult      <= 4'h1;
			range_mult   <= 4'h1;
			lock_irq     <= 1'h0;
		end else if (ce) begin
			loop_active  <= loop_enable & ~l_zero;
			filter_track <= next_filter;
			fb_mult      <= pbc_n_eff(prog_n);
			range_mult   <= prog_l;
			lock_irq     <= auto_mode & lock_irq_en & lock_change_flag;
		end
	end

	pbc_clk_sel u_clk_sel (
		.pclk         (pclk),
		.presetn      (presetn),
		.ce           (ce),
		.want_vco     (base_src_sel),
		.xtal_clk     (xtal_clk),
		.vco_clk      (vco_clk),
		.base_clk_out (base_clk_out),
		.using_vco    (using_vco),
		.xtal_rise    (xtal_rise),
		.vco_rise     (vco_rise)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_manual_no_irq: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && !auto_mode) |=> !lock_irq)
		else $error("interrupt raised in manual mode");

	a_manual_no_lock: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && !auto_mode) |=> !lock_st)
		else $error("lock indicated in manual mode");

	a_flag_on_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		(auto_mode && lock_st != $past(lock_st)) |-> lock_change_flag)
		else $error("lock toggled without setting the change flag");

	a_flag_read_clr: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && rd_ctrl && !lock_set) |=> !lock_change_flag)
		else $error("control read did not clear the change flag");

	a_vco_needs_loop: assert property (@(posedge pclk) disable iff (!presetn)
		base_src_sel |-> (loop_enable && !l_zero))
		else $error("vco selected with loop off or range zero");

	a_single_switch: assert property (@(posedge pclk) disable iff (!presetn)
		!(loop_enable != $past(loop_enable) && base_src_sel != $past(base_src_sel)))
		else $error("enable and select changed in one write");

	a_range_zero_off: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && l_zero) |=> (!loop_active && !base_src_sel))
		else $error("zero range left the loop active");

	a_irq_two_steps: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && lock_set && auto_mode && lock_irq_en) ##1 ce |=> lock_irq)
		else $error("lock change did not raise the interrupt");

endmodule : pbc_pll_ctrl

`default_nettype wire

// >>> common/pbc_pkg.sv
/*
 * Constants, types and helpers shared by the PLL bandwidth and base clock select block.
 * Assumes a single pclk domain; the crystal and VCO clocks are sampled as plain inputs.
 */
`default_nettype none

package pbc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses on the APB)
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_BW        = 8'h04;
	localparam logic [7:0]  ADDR_PROG      = 8'h08;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          CTRL_IRQ_EN    = 7;
	localparam int          CTRL_FLAG      = 6;
	localparam int          CTRL_ENABLE    = 5;
	localparam int          CTRL_BSEL      = 4;
	localparam logic [3:0]  CTRL_UNUSED    = 4'hf;
	localparam int          BW_AUTO        = 7;
	localparam int          BW_LOCK        = 6;
	localparam int          BW_TRACK       = 5;
	localparam logic [7:0]  PROG_RST       = 8'h11;
	localparam logic        ENABLE_RST     = 1'h1;

	// ----------------------------------------------------------------
	// lock detector: one window is REF_WIN crystal edges, tolerances in vco edges
	// ----------------------------------------------------------------
	localparam logic [3:0]  REF_WIN        = 4'h8;
	localparam logic [7:0]  LOCK_TOL       = 8'h02;
	localparam logic [7:0]  UNLOCK_TOL     = 8'h04;
	localparam logic [7:0]  TRACK_TOL      = 8'h04;
	localparam logic [7:0]  UNTRACK_TOL    = 8'h08;

	// ----------------------------------------------------------------
	// clock switch
	// ----------------------------------------------------------------
	localparam logic [1:0]  SWITCH_EDGES   = 2'h3;

	typedef enum {SEL_RUN, SEL_OLD, SEL_NEW} pbc_sel_state_e;

	function automatic logic [7:0] pbc_absdiff(input logic [7:0] a, input logic [7:0] b);
		pbc_absdiff = (a > b) ? 8'(a - b) : 8'(b - a);
	endfunction : pbc_absdiff

	function automatic logic [3:0] pbc_n_eff(input logic [3:0] n);
		pbc_n_eff = (n == 4'h0) ? 4'h1 : n;
	endfunction : pbc_n_eff

endpackage : pbc_pkg

`default_nettype wire

// >>> logic/pbc_clk_sel.sv
/*
 * Glitch-free base clock selector with divide-by-two, plus edge pulses of both sources.
 * Assumes xtal_clk and vco_clk are asynchronous pins well below half the pclk rate.
 */
`timescale 1ns/1ps
`default_nettype none

module pbc_clk_sel
	import pbc_pkg::*;
(
	// clock, reset, enable
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// control
	input  wire logic want_vco,
	// source clocks
	input  wire logic xtal_clk,
	input  wire logic vco_clk,
	// results
	output logic      base_clk_out,
	output logic      using_vco,
	output logic      xtal_rise,
	output logic      vco_rise
);

	logic [2:0]      xs;
	logic [2:0]      vs;
	logic [1:0]      cnt;
	pbc_sel_state_e  state;

	wire xtal_rise_c = xs[1] & ~xs[2];
	wire vco_rise_c  = vs[1] & ~vs[2];
	wire src_rise    = using_vco ? vco_rise_c : xtal_rise_c;
	wire tgt_rise    = using_vco ? xtal_rise_c : vco_rise_c;
	wire last_edge   = (cnt == 2'(SWITCH_EDGES - 2'h1));

	// ----------------------------------------------------------------
	// synchronisers: xs[0]/vs[0] feed only the second stage
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xs        <= 3'h0;
			vs        <= 3'h0;
			xtal_rise <= 1'h0;
			vco_rise  <= 1'h0;
		end else if (ce) begin
			xs        <= {xs[1:0], xtal_clk};
			vs        <= {vs[1:0], vco_clk};
			xtal_rise <= xtal_rise_c;
			vco_rise  <= vco_rise_c;
		end
	end

	// ----------------------------------------------------------------
	// switch sequencer: drain old source, then arm new, output frozen
	// ----------------------------------------------------------------
	// limitation: a dead old source stalls the switch; the output stays static meanwhile
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state        <= SEL_RUN;
			cnt          <= 2'h0;
			using_vco    <= 1'h0;
			base_clk_out <= 1'h0;
		end else if (ce) begin
			case (state)
				SEL_RUN: begin
					if (want_vco != using_vco) begin
						state <= SEL_OLD;
						cnt   <= 2'h0;
					end else if (src_rise) begin
						base_clk_out <= ~base_clk_out;
					end
				end
				SEL_OLD: begin
					if (src_rise) begin
						cnt   <= last_edge ? 2'h0 : 2'(cnt + 2'h1);
						state <= last_edge ? SEL_NEW : SEL_OLD;
					end
				end
				SEL_NEW: begin
					if (tgt_rise) begin
						cnt   <= last_edge ? 2'h0 : 2'(cnt + 2'h1);
						state <= last_edge ? SEL_RUN : SEL_NEW;
						if (last_edge) begin
							using_vco <= ~using_vco;
						end
					end
				end
				default: state <= SEL_RUN;
			endcase
		end
	end

	a_out_stasis: assert property (@(posedge pclk) disable iff (!presetn)
		(state != SEL_RUN) |=> $stable(base_clk_out))
		else $error("base clock moved during a source switch");

	a_div_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && state == SEL_RUN && want_vco == using_vco && src_rise)
			|=> base_clk_out != $past(base_clk_out))
		else $error("base clock did not toggle on a source edge");

endmodule : pbc_clk_sel

`default_nettype wire

// >>> sim/pbc_osc_model.sv
/*
 * Crystal and vco source model for the pll control bench.
 * Assumes fb_mult stays at 1 or 2, so every pin edge is 200 ns or more apart.
 */
`timescale 1ns/1ps
`default_nettype none

module pbc_osc_model (
	// loop state from the block
	input  wire logic       run,
	input  wire logic [3:0] mult,
	// bench control
	input  wire logic       detune,
	// source clocks
	output logic            xtal_clk,
	output logic            vco_clk
);
	int hp;

	// ----------------------------------------------------------------
	// crystal runs free at 1 MHz; edges kept clear of pclk edges
	// ----------------------------------------------------------------
	initial begin
		xtal_clk = 1'b0;
		#23;
		forever begin
			xtal_clk = ~xtal_clk;
			#500;
		end
	end

	// ----------------------------------------------------------------
	// vco stops while the loop is off; detune stands for a severe noise hit
	// ----------------------------------------------------------------
	initial begin
		vco_clk = 1'b0;
		#37;
		forever begin
			if (run !== 1'b1) begin
				vco_clk = 1'b0;
				#100;
			end else begin
				hp = detune ? 200 : 500 / int'(mult);
				vco_clk = ~vco_clk;
				#hp;
			end
		end
	end
endmodule : pbc_osc_model

`default_nettype wire

// >>> sim/pll_bandwidth_and_base_clock_select_bench.sv
/*
 * Directed bench for pbc_pll_ctrl: apb tasks, register and clock checks.
 * Assumes pbc_osc_model drives the crystal and vco pins.
 */
`timescale 1ns/1ps
`default_nettype none

module pll_bandwidth_and_base_clock_select_bench
	import pbc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, detune, serr, bs;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, base_clk_out, loop_active, filter_track, lock_irq;
	logic        xtal_clk, vco_clk;
	logic [3:0]  fb_mult, range_mult;
	int          n_fail, total_checks, g, i;

	pbc_pll_ctrl u_pbc_pll_ctrl (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .xtal_clk(xtal_clk), .vco_clk(vco_clk),
		.base_clk_out(base_clk_out), .loop_active(loop_active),
		.filter_track(filter_track), .fb_mult(fb_mult), .range_mult(range_mult),
		.lock_irq(lock_irq));

	pbc_osc_model u_pbc_osc_model (
		.run(loop_active), .mult(fb_mult), .detune(detune),
		.xtal_clk(xtal_clk), .vco_clk(vco_clk));

	initial pclk = 1'b0;
	always #50 pclk = ~pclk;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// request held until pready is sampled high; data taken at that edge
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			n_fail++;
			complete_run();
		end
		rdat = prdata;
		serr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	// outputs built from a written register settle one edge after the write lands
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(a, 1'b1, d);
		repeat (2) @(posedge pclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		xfer(a, 1'b0, 8'h00);
		chk(rdat, {24'h0, exp});
	endtask : rd

	task automatic wait_irq;
		int k;
		for (k = 0; k < 1500; k++) begin
			@(posedge pclk);
			if (lock_irq === 1'b1) break;
		end
		if (k == 1500) begin
			n_fail++;
			complete_run();
		end
	endtask : wait_irq

	// pclk cycles between two toggles of the base clock
	task automatic gap(output int n);
		logic b;
		int k;
		b = base_clk_out;
		for (k = 0; k < 60 && base_clk_out === b; k++) @(posedge pclk);
		b = base_clk_out;
		for (n = 0; n < 60 && base_clk_out === b; n++) @(posedge pclk);
	endtask : gap

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		detune = 1'b0;
		n_fail = 0;
		total_checks = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_CTRL, 8'h2f);
		rd(ADDR_BW, 8'h00);
		rd(ADDR_PROG, PROG_RST);
		chk({31'h0, loop_active}, 32'h1);
		xfer(8'h0c, 1'b0, 8'h00);
		chk({31'h0, serr}, 32'h1);
		chk(rdat, 32'h0);
		wr(ADDR_PROG, 8'h05);
		chk({28'h0, fb_mult}, 32'h1);
		chk({28'h0, range_mult}, 32'h5);
		wr(ADDR_PROG, 8'h21);
		chk({28'h0, fb_mult}, 32'h2);
		gap(g);
		chk(32'(g), 32'd10);
		// manual mode: track bit drives the filter, no lock or interrupt
		wr(ADDR_BW, 8'h20);
		chk({31'h0, filter_track}, 32'h1);
		rd(ADDR_BW, 8'h20);
		wr(ADDR_CTRL, 8'ha0);
		rd(ADDR_CTRL, 8'h2f);
		chk({31'h0, lock_irq}, 32'h0);
		wr(ADDR_BW, 8'h00);
		chk({31'h0, filter_track}, 32'h0);
		// interlocks between loop enable and source select
		wr(ADDR_CTRL, 8'h00);
		rd(ADDR_CTRL, 8'h0f);
		chk({31'h0, loop_active}, 32'h0);
		wr(ADDR_CTRL, 8'h30);
		rd(ADDR_CTRL, 8'h0f);
		wr(ADDR_CTRL, 8'h10);
		rd(ADDR_CTRL, 8'h0f);
		wr(ADDR_CTRL, 8'h20);
		repeat (20) @(posedge pclk);
		wr(ADDR_BW, 8'h20);
		repeat (20) @(posedge pclk);
		wr(ADDR_CTRL, 8'h30);
		repeat (3) @(posedge pclk);
		bs = base_clk_out;
		for (i = 0; i < 12; i++) begin
			@(posedge pclk);
			chk({31'h0, base_clk_out}, {31'h0, bs});
		end
		gap(g);
		gap(g);
		chk(32'(g), 32'd5);
		rd(ADDR_CTRL, 8'h3f);
		wr(ADDR_CTRL, 8'h00);
		rd(ADDR_CTRL, 8'h3f);
		wr(ADDR_CTRL, 8'h10);
		rd(ADDR_CTRL, 8'h3f);
		wr(ADDR_PROG, 8'h20);
		rd(ADDR_CTRL, 8'h2f);
		chk({31'h0, loop_active}, 32'h0);
		wr(ADDR_PROG, 8'h11);
		// automatic mode: lock, track, flag and interrupt
		wr(ADDR_BW, 8'h80);
		wr(ADDR_CTRL, 8'ha0);
		wait_irq();
		rd(ADDR_BW, 8'he0);
		chk({31'h0, filter_track}, 32'h1);
		rd(ADDR_CTRL, 8'hef);
		rd(ADDR_CTRL, 8'haf);
		chk({31'h0, lock_irq}, 32'h0);
		detune <= 1'b1;
		wait_irq();
		repeat (200) @(posedge pclk);
		rd(ADDR_BW, 8'h80);
		chk({31'h0, filter_track}, 32'h0);
		wr(ADDR_CTRL, 8'h20);
		repeat (2) @(posedge pclk);
		chk({31'h0, lock_irq}, 32'h0);
		rd(ADDR_CTRL, 8'h6f);
		wr(ADDR_BW, 8'h00);
		rd(ADDR_CTRL, 8'h2f);
		complete_run();
	end
endmodule : pll_bandwidth_and_base_clock_select_bench

`default_nettype wire
